//--- verilog/bdsp_pkg.sv
package bdsp_pkg;

  // ------------------------------------------------------------------
  // packet framing
  // ------------------------------------------------------------------
  localparam int          PKT_BITS       = 17;
  localparam int          WORD_BITS      = 16;
  localparam logic [4:0]  LAST_BIT_IDX   = 5'h10;
  localparam int          ACCEPT_CYCLES  = 32;

  // ------------------------------------------------------------------
  // response words {status, data}
  // ------------------------------------------------------------------
  localparam logic [16:0] RESP_OK        = 17'h0FFFF;
  localparam logic [16:0] RESP_NOT_READY = 17'h10000;
  localparam logic [16:0] RESP_BUS_ERR   = 17'h10001;
  localparam logic [16:0] RESP_ILLEGAL   = 17'h1FFFF;

  // ------------------------------------------------------------------
  // command codes and fields
  // ------------------------------------------------------------------
  localparam logic [11:0] OPC_RREG_HI    = 12'h218;
  localparam logic [11:0] OPC_WREG_HI    = 12'h208;
  localparam logic [15:0] OPC_RMEM       = 16'h1900;
  localparam logic [15:0] OPC_WMEM       = 16'h1800;
  localparam logic [15:0] OPC_DUMP       = 16'h1D00;
  localparam logic [15:0] OPC_FILL       = 16'h1C00;
  localparam logic [15:0] OPC_SIZE_MASK  = 16'hFF3F;
  localparam logic [15:0] OPC_GO         = 16'h0C00;
  localparam logic [15:0] OPC_NOP        = 16'h0000;
  localparam logic [15:0] OPC_SYNC       = 16'h0001;
  localparam logic [15:0] OPC_RCTL       = 16'h2980;
  localparam logic [15:0] OPC_WCTL       = 16'h2880;
  localparam logic [7:0]  OPC_RDBG_HI    = 8'h2D;
  localparam logic [7:0]  OPC_WDBG_HI    = 8'h2C;
  localparam logic [2:0]  DBG_FIXED      = 3'h4;
  localparam int          SZ_LSB         = 6;
  localparam logic [1:0]  SZ_BYTE        = 2'b00;
  localparam logic [1:0]  SZ_WORD        = 2'b01;
  localparam logic [1:0]  SZ_LONG        = 2'b10;
  localparam logic [1:0]  SZ_RSVD        = 2'b11;
  localparam logic [2:0]  ADDR_WORDS     = 3'h2;

  typedef enum logic [1:0] {
    SP_CORE = 2'b00,
    SP_CTRL = 2'b01,
    SP_DBG  = 2'b10
  } bdsp_space_e;

  typedef enum logic [2:0] {
    ST_CMD  = 3'b000,
    ST_EXT  = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b011,
    ST_RES2 = 3'b100
  } bdsp_state_e;

  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    size_bytes = (sz == SZ_LONG) ? 32'h4 : ((sz == SZ_WORD) ? 32'h2 : 32'h1);
  endfunction

  function automatic logic [2:0] data_words(input logic [1:0] sz);
    data_words = (sz == SZ_LONG) ? 3'h2 : 3'h1;
  endfunction

endpackage

//--- verilog/bdsp_ser_if.sv
`timescale 1ns/1ns
interface bdsp_ser_if;
  logic [15:0] rx_word;
  logic        rx_ctl;
  logic        rx_valid;
  logic [16:0] tx_word;

  modport shifter (output rx_word, output rx_ctl, output rx_valid, input tx_word);
  modport decoder (input rx_word, input rx_ctl, input rx_valid, output tx_word);
endinterface

//--- verilog/bdsp_shift.sv
`timescale 1ns/1ns
module bdsp_shift
  import bdsp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       sclk_i,
  input  wire logic       sdin_i,
  output logic            sdout_o,
  bdsp_ser_if.shifter     ser
);

  logic        sclk_s1_r;
  logic        sclk_s2_r;
  logic        sclk_d_r;
  logic        din_s1_r;
  logic        din_s2_r;
  logic        bit_edge;
  logic [4:0]  cnt_r;
  logic [15:0] rx_sr_r;
  logic [16:0] tx_sr_r;
  logic [16:0] tx_cur;
  logic        bit_r;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_d_r  <= 1'b0;
      din_s1_r  <= 1'b0;
      din_s2_r  <= 1'b0;
    end else begin
      sclk_s1_r <= sclk_i;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r  <= sclk_s2_r;
      din_s1_r  <= sdin_i;
      din_s2_r  <= din_s1_r;
    end
  end

  // a new bit only after the clock was seen low
  assign bit_edge = sclk_s2_r & ~sclk_d_r;
  assign tx_cur   = (cnt_r == 5'h00) ? ser.tx_word : tx_sr_r;

  // ----------------------------------------------------------------
  // bit exchange
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cnt_r        <= 5'h00;
      rx_sr_r      <= 16'h0000;
      tx_sr_r      <= 17'h00000;
      bit_r        <= 1'b0;
      ser.rx_valid <= 1'b0;
      ser.rx_word  <= 16'h0000;
      ser.rx_ctl   <= 1'b0;
    end else begin
      ser.rx_valid <= 1'b0;
      if (bit_edge) begin
        bit_r   <= tx_cur[16];
        tx_sr_r <= {tx_cur[15:0], 1'b0};
        if (cnt_r == LAST_BIT_IDX) begin
          cnt_r        <= 5'h00;
          ser.rx_valid <= 1'b1;
          ser.rx_word  <= {rx_sr_r[14:0], din_s2_r};
          ser.rx_ctl   <= rx_sr_r[15];
        end else begin
          cnt_r   <= cnt_r + 5'h01;
          rx_sr_r <= {rx_sr_r[14:0], din_s2_r};
          if (cnt_r == 5'h00) begin
            rx_sr_r <= {15'h0000, din_s2_r};
          end
        end
      end
    end
  end

  // output pin one cycle after the state change
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sdout_o <= 1'b0;
    end else begin
      sdout_o <= bit_r;
    end
  end

endmodule // bdsp_shift

//--- verilog/bdsp_top.sv
// Behaviour
// - full duplex 17-bit packets, status plus word
// - transitions on clk edge with clock high
// - two sync cycles, state, then output
// - most significant bit first both ways
// - new transfer accepted within 32 clocks
// - response status and data encodings
// - core register read and write, halted
// - memory read byte word long, stolen
// - memory write byte word long, stolen
// - dump reads successive locations after read
// - fill writes successive locations after write
// - resume restarts at current pc, halted
// - no-op and pc sync run alongside
// - control register read and write, halted
// - debug unit registers, fixed 4 field
// - unassigned codes return illegal response
// - size bits byte word long reserved
// - extension words most significant first
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
module bdsp_top
  import bdsp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        serial_debug_clock_i,
  input  wire logic        serial_debug_in_i,
  output logic             serial_debug_out_o,
  input  wire logic        cpu_halted_i,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [1:0]       mem_size_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic        mem_err_i,
  input  wire logic [31:0] mem_rdata_i,
  output logic             reg_req_o,
  output logic             reg_we_o,
  output logic [1:0]       reg_space_o,
  output logic [4:0]       reg_sel_o,
  output logic [31:0]      reg_wdata_o,
  input  wire logic        reg_ack_i,
  input  wire logic        reg_err_i,
  input  wire logic [31:0] reg_rdata_i,
  output logic             resume_o,
  output logic             pc_sync_o
);

  bdsp_ser_if ser ();

  bdsp_state_e state_r;
  logic [16:0] resp_r;
  logic [15:0] low_hold_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic [2:0]  addr_left_r;
  logic [2:0]  data_left_r;
  logic        is_mem_r;
  logic        is_wr_r;
  logic [1:0]  size_r;
  bdsp_space_e space_r;
  logic [4:0]  sel_r;
  logic        rd_chain_r;
  logic        wr_chain_r;

  // decode results
  logic [15:0] w;
  logic [1:0]  d_sz;
  logic        d_known;
  logic        d_mem;
  logic        d_wr;
  logic        d_blk;
  logic        d_halt;
  logic        d_nop;
  logic        d_sync;
  logic        d_go;
  bdsp_space_e d_space;
  logic [4:0]  d_sel;
  logic [2:0]  d_addr_n;
  logic [2:0]  d_data_n;
  logic        d_chain_ok;
  logic        d_start;
  logic        ack;
  logic        err;
  logic [31:0] rdata;
  logic        ext_last;

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  bdsp_shift u_shift (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .sclk_i    (serial_debug_clock_i),
    .sdin_i    (serial_debug_in_i),
    .sdout_o   (serial_debug_out_o),
    .ser       (ser)
  );

  assign ser.tx_word = resp_r;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign w    = ser.rx_word;
  assign d_sz = w[SZ_LSB +: 2];

  always_comb begin
    d_known  = 1'b1;
    d_mem    = 1'b0;
    d_wr     = 1'b0;
    d_blk    = 1'b0;
    d_halt   = 1'b0;
    d_nop    = 1'b0;
    d_sync   = 1'b0;
    d_go     = 1'b0;
    d_space  = SP_CORE;
    d_sel    = 5'h00;
    d_addr_n = 3'h0;
    d_data_n = 3'h0;
    if (w[15:4] == OPC_RREG_HI || w[15:4] == OPC_WREG_HI) begin
      d_halt   = 1'b1;
      d_wr     = (w[15:4] == OPC_WREG_HI);
      d_sel    = {1'b0, w[3:0]};
      d_data_n = d_wr ? data_words(SZ_LONG) : 3'h0;
    end else if ((w & OPC_SIZE_MASK) == OPC_RMEM || (w & OPC_SIZE_MASK) == OPC_WMEM) begin
      d_mem    = 1'b1;
      d_wr     = ((w & OPC_SIZE_MASK) == OPC_WMEM);
      d_addr_n = ADDR_WORDS;
      d_data_n = d_wr ? data_words(d_sz) : 3'h0;
      d_known  = (d_sz != SZ_RSVD);
    end else if ((w & OPC_SIZE_MASK) == OPC_DUMP || (w & OPC_SIZE_MASK) == OPC_FILL) begin
      d_mem    = 1'b1;
      d_blk    = 1'b1;
      d_wr     = ((w & OPC_SIZE_MASK) == OPC_FILL);
      d_data_n = d_wr ? data_words(d_sz) : 3'h0;
      d_known  = (d_sz != SZ_RSVD);
    end else if (w == OPC_GO) begin
      d_go     = 1'b1;
      d_halt   = 1'b1;
    end else if (w == OPC_NOP) begin
      d_nop    = 1'b1;
    end else if (w == OPC_SYNC) begin
      d_sync   = 1'b1;
    end else if (w == OPC_RCTL || w == OPC_WCTL) begin
      d_halt   = 1'b1;
      d_space  = SP_CTRL;
      d_wr     = (w == OPC_WCTL);
      d_data_n = d_wr ? data_words(SZ_LONG) : 3'h0;
    end else if ((w[15:8] == OPC_RDBG_HI || w[15:8] == OPC_WDBG_HI) && w[7:5] == DBG_FIXED) begin
      d_space  = SP_DBG;
      d_wr     = (w[15:8] == OPC_WDBG_HI);
      d_sel    = w[4:0];
      d_data_n = d_wr ? data_words(SZ_LONG) : 3'h0;
    end else begin
      d_known  = 1'b0;
    end
  end

  assign d_chain_ok = !d_blk || (d_wr ? wr_chain_r : rd_chain_r);
  assign d_start    = (state_r == ST_CMD) && ser.rx_valid && d_known && d_chain_ok &&
                      !(d_halt && !cpu_halted_i) && !d_nop && !d_sync && !d_go;
  assign ext_last   = (addr_left_r + data_left_r) == 3'h1;

  assign ack   = is_mem_r ? mem_ack_i : reg_ack_i;
  assign err   = is_mem_r ? mem_err_i : reg_err_i;
  assign rdata = is_mem_r ? mem_rdata_i : reg_rdata_i;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_r <= ST_CMD;
    end else begin
      unique case (state_r)
        ST_CMD: begin
          if (d_start) begin
            state_r <= ((d_addr_n + d_data_n) == 3'h0) ? ST_EXEC : ST_EXT;
          end
        end
        ST_EXT: begin
          if (ser.rx_valid && ext_last) begin
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (ack) begin
            state_r <= (!err && !is_wr_r && (!is_mem_r || size_r == SZ_LONG)) ? ST_RES2 : ST_CMD;
          end
        end
        ST_RES2: begin
          if (ser.rx_valid) begin
            state_r <= ST_CMD;
          end
        end
        default: begin
          state_r <= ST_CMD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // response word for the next packet
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      resp_r     <= RESP_OK;
      low_hold_r <= 16'h0000;
    end else begin
      if (state_r == ST_CMD && ser.rx_valid) begin
        if (!d_known || !d_chain_ok) begin
          resp_r <= RESP_ILLEGAL;
        end else if (d_halt && !cpu_halted_i) begin
          resp_r <= RESP_BUS_ERR;
        end else if (d_nop || d_sync || d_go) begin
          resp_r <= RESP_OK;
        end else begin
          resp_r <= RESP_NOT_READY;
        end
      end else if (state_r == ST_WAIT && ack) begin
        low_hold_r <= rdata[15:0];
        if (err) begin
          resp_r <= RESP_BUS_ERR;
        end else if (is_wr_r) begin
          resp_r <= RESP_OK;
        end else if (!is_mem_r || size_r == SZ_LONG) begin
          resp_r <= {1'b0, rdata[31:16]};
        end else if (size_r == SZ_BYTE) begin
          resp_r <= {1'b0, 8'h00, rdata[7:0]};
        end else begin
          resp_r <= {1'b0, rdata[15:0]};
        end
      end else if (state_r == ST_RES2 && ser.rx_valid) begin
        resp_r <= {1'b0, low_hold_r};
      end
    end
  end

  // ----------------------------------------------------------------
  // operation fields, address and operand
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      addr_r      <= 32'h00000000;
      data_r      <= 32'h00000000;
      addr_left_r <= 3'h0;
      data_left_r <= 3'h0;
      is_mem_r    <= 1'b0;
      is_wr_r     <= 1'b0;
      size_r      <= SZ_LONG;
      space_r     <= SP_CORE;
      sel_r       <= 5'h00;
    end else begin
      if (d_start) begin
        addr_left_r <= d_addr_n;
        data_left_r <= d_data_n;
        is_mem_r    <= d_mem;
        is_wr_r     <= d_wr;
        size_r      <= d_mem ? d_sz : SZ_LONG;
        space_r     <= d_space;
        sel_r       <= d_sel;
        data_r      <= 32'h00000000;
        if (d_blk) begin
          addr_r <= addr_r + size_bytes(d_sz);
        end
      end else if (state_r == ST_EXT && ser.rx_valid) begin
        if (addr_left_r != 3'h0) begin
          addr_r      <= {addr_r[15:0], w};
          addr_left_r <= addr_left_r - 3'h1;
        end else begin
          data_r      <= {data_r[15:0], w};
          data_left_r <= data_left_r - 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // block chain validity
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rd_chain_r <= 1'b0;
      wr_chain_r <= 1'b0;
    end else begin
      if (state_r == ST_CMD && ser.rx_valid) begin
        rd_chain_r <= rd_chain_r && d_blk && !d_wr && d_known;
        wr_chain_r <= wr_chain_r && d_blk && d_wr && d_known;
      end else if (state_r == ST_WAIT && ack && is_mem_r) begin
        rd_chain_r <= !err && !is_wr_r;
        wr_chain_r <= !err && is_wr_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory and register requests, held until acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_size_o  <= SZ_LONG;
      mem_addr_o  <= 32'h00000000;
      mem_wdata_o <= 32'h00000000;
      reg_req_o   <= 1'b0;
      reg_we_o    <= 1'b0;
      reg_space_o <= SP_CORE;
      reg_sel_o   <= 5'h00;
      reg_wdata_o <= 32'h00000000;
    end else begin
      if (state_r == ST_EXEC) begin
        if (is_mem_r) begin
          mem_req_o   <= 1'b1;
          mem_we_o    <= is_wr_r;
          mem_size_o  <= size_r;
          mem_addr_o  <= addr_r & ~(size_bytes(size_r) - 32'h1);
          mem_wdata_o <= data_r;
        end else begin
          reg_req_o   <= 1'b1;
          reg_we_o    <= is_wr_r;
          reg_space_o <= space_r;
          reg_sel_o   <= sel_r;
          reg_wdata_o <= data_r;
        end
      end else if (state_r == ST_WAIT && ack) begin
        mem_req_o <= 1'b0;
        reg_req_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // resume and pc sync pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      resume_o  <= 1'b0;
      pc_sync_o <= 1'b0;
    end else begin
      resume_o  <= (state_r == ST_CMD) && ser.rx_valid && d_go && cpu_halted_i;
      pc_sync_o <= (state_r == ST_CMD) && ser.rx_valid && d_sync;
    end
  end

endmodule // bdsp_top

//--- verification/bdsp_top_properties.sv
`timescale 1ns/1ns
module bdsp_checker
  import bdsp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        serial_debug_clock_i,
  input  wire logic        serial_debug_out_o,
  input  wire logic        cpu_halted_i,
  input  wire logic        mem_req_o,
  input  wire logic        mem_we_o,
  input  wire logic [1:0]  mem_size_o,
  input  wire logic [31:0] mem_addr_o,
  input  wire logic        mem_ack_i,
  input  wire logic        reg_req_o,
  input  wire logic [1:0]  reg_space_o,
  input  wire logic        reg_ack_i,
  input  wire logic        resume_o,
  input  wire logic        pc_sync_o
);
  // ----------------------------------------------------------------
  // handshake steps
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_mem_wait; mem_req_o && !mem_ack_i; endsequence
  sequence s_mem_done; mem_req_o && mem_ack_i; endsequence
  sequence s_reg_wait; reg_req_o && !reg_ack_i; endsequence
  sequence s_reg_done; reg_req_o && reg_ack_i; endsequence

  a_out_after_rise: assert property ($changed(serial_debug_out_o) |->
    $past(serial_debug_clock_i, 2) && !$past(serial_debug_clock_i, 8))
    else $error("serial out moved away from a clock rise");
  a_mem_req_hold: assert property (s_mem_wait |=> mem_req_o && $stable(mem_addr_o)
    && $stable(mem_we_o) && $stable(mem_size_o)) else $error("memory request not held");
  a_mem_req_drop: assert property (s_mem_done |=> !mem_req_o)
    else $error("memory request not dropped");
  a_reg_req_hold: assert property (s_reg_wait |=> reg_req_o && $stable(reg_space_o))
    else $error("register request not held");
  a_reg_req_drop: assert property (s_reg_done |=> !reg_req_o)
    else $error("register request not dropped");
  a_mem_size_align: assert property (mem_req_o |-> mem_size_o != SZ_RSVD
    && (mem_size_o == SZ_BYTE || !mem_addr_o[0])
    && (mem_size_o != SZ_LONG || mem_addr_o[1:0] == 2'b00))
    else $error("bad memory size or alignment");
  a_halted_only: assert property ($rose(reg_req_o) && reg_space_o != SP_DBG
    |-> cpu_halted_i) else $error("core access while running");
  a_resume_pulse: assert property (resume_o |-> cpu_halted_i ##1 !resume_o)
    else $error("bad resume pulse");
  a_sync_pulse: assert property (pc_sync_o |=> !pc_sync_o)
    else $error("pc sync pulse too long");
  a_req_after_bit: assert property ($rose(mem_req_o) || $rose(reg_req_o)
    |-> $past(serial_debug_clock_i, 2)) else $error("request not after a received bit");
endmodule // bdsp_checker

bind bdsp_top bdsp_checker i_bdsp_checker (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .serial_debug_clock_i(serial_debug_clock_i),
  .serial_debug_out_o(serial_debug_out_o), .cpu_halted_i(cpu_halted_i),
  .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_size_o(mem_size_o),
  .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .reg_req_o(reg_req_o),
  .reg_space_o(reg_space_o), .reg_ack_i(reg_ack_i), .resume_o(resume_o),
  .pc_sync_o(pc_sync_o)
);

//--- verification/bdsp_devsys.sv
`timescale 1ns/1ns
module bdsp_devsys
  import bdsp_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic sdout_i,
  output logic      sclk_o,
  output logic      sdata_o
);
  // ----------------------------------------------------------------
  // serial master
  // ----------------------------------------------------------------
  localparam int HALF = 20;
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b1;
  end
  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    repeat (ACCEPT_CYCLES) @(posedge clk_sys_i);
    for (int i = 16; i >= 0; i--) begin
      sdata_o <= tx[i];
      repeat (HALF) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge clk_sys_i);
      rx[i] = sdout_i;
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys_i);
    sdata_o <= ~tx[0];
  endtask
endmodule // bdsp_devsys

//--- verification/bdsp_top_bench.sv
`timescale 1ns/1ns
module bdsp_top_bench
  import bdsp_pkg::*;
;
  localparam logic [16:0] OK = RESP_OK;
  localparam logic [16:0] NR = RESP_NOT_READY;
  localparam logic [16:0] BE = RESP_BUS_ERR;
  localparam logic [16:0] IL = RESP_ILLEGAL;
  logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, halted = 1'b1, err_en = 1'b0;
  logic        sclk, sdin, sdout, resume, pc_sync;
  logic        mem_req, mem_we, mem_ack = 1'b0, mem_err = 1'b0;
  logic        reg_req, reg_we, reg_ack = 1'b0, reg_err = 1'b0;
  logic [1:0]  mem_size, reg_space, wr_size, rg_space;
  logic [4:0]  reg_sel, rg_sel;
  logic [31:0] mem_addr, mem_wdata, mem_rdata = 32'h0, reg_wdata, reg_rdata = 32'h0;
  logic [31:0] wr_addr, wr_data, rg_data, n_res = 32'h0, n_sync = 32'h0;
  int          fails = 0, comparisons = 0, cycles = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  bdsp_top i_bdsp_top (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .serial_debug_clock_i(sclk),
    .serial_debug_in_i(sdin), .serial_debug_out_o(sdout), .cpu_halted_i(halted),
    .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_size_o(mem_size), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_err_i(mem_err),
    .mem_rdata_i(mem_rdata), .reg_req_o(reg_req), .reg_we_o(reg_we),
    .reg_space_o(reg_space), .reg_sel_o(reg_sel), .reg_wdata_o(reg_wdata),
    .reg_ack_i(reg_ack), .reg_err_i(reg_err), .reg_rdata_i(reg_rdata),
    .resume_o(resume), .pc_sync_o(pc_sync));

  bdsp_devsys i_bdsp_devsys (.clk_sys_i(clk_sys_i), .sdout_i(sdout), .sclk_o(sclk),
    .sdata_o(sdin));

  // ----------------------------------------------------------------
  // memory and register responders
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    mem_ack <= mem_req && !mem_ack;
    mem_err <= err_en && mem_req && !mem_ack;
    mem_rdata <= {mem_addr[15:0] ^ 16'h5A5A, mem_addr[15:0]};
    reg_ack <= reg_req && !reg_ack;
    reg_rdata <= {reg_space, 25'h0, reg_sel} ^ 32'hF00D0000;
    if (mem_req && mem_we && mem_ack) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_size <= mem_size;
    end
    if (reg_req && reg_we && reg_ack) begin
      rg_data <= reg_wdata;
      rg_space <= reg_space;
      rg_sel <= reg_sel;
    end
    n_res <= n_res + {31'h0, resume};
    n_sync <= n_sync + {31'h0, pc_sync};
    cycles <= cycles + 1;
    if (cycles == 45000) begin
      fails++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pkt(input logic [15:0] w, input logic [16:0] exp);
    logic [16:0] rx;
    i_bdsp_devsys.xfer({1'b0, w}, rx);
    chk({15'h0, rx}, {15'h0, exp});
  endtask
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    pkt(OPC_NOP, OK);
    pkt(16'h3FFF, OK);
    pkt(16'h19C0, IL);
    pkt(OPC_SYNC, IL);
    pkt(OPC_NOP, OK);
    chk(n_sync, 32'h1);
    pkt(16'h1840, OK);
    pkt(16'h0000, NR);
    pkt(16'h1000, NR);
    pkt(16'hBEEF, NR);
    pkt(16'h1C40, OK);
    chk({14'h0, wr_size, wr_data[15:0]}, 32'h0001BEEF);
    chk(wr_addr, 32'h00001000);
    pkt(16'h1234, NR);
    pkt(16'h1880, OK);
    chk(wr_addr, 32'h00001002);
    chk(wr_data, 32'h00001234);
    pkt(16'h0000, NR);
    pkt(16'h3000, NR);
    pkt(16'hCAFE, NR);
    pkt(16'hF00D, NR);
    pkt(16'h1980, OK);
    chk(wr_data, 32'hCAFEF00D);
    chk(wr_addr, 32'h00003000);
    pkt(16'h0000, NR);
    pkt(16'h2000, NR);
    pkt(OPC_NOP, 17'h07A5A);
    pkt(16'h1D00, 17'h02000);
    pkt(OPC_NOP, 17'h00001);
    pkt(16'h1D40, OK);
    pkt(OPC_NOP, IL);
    err_en <= 1'b1;
    pkt(16'h1940, OK);
    pkt(16'h0000, NR);
    pkt(16'h2002, NR);
    pkt(OPC_NOP, BE);
    err_en <= 1'b0;
    halted <= 1'b0;
    pkt(16'h218B, OK);
    pkt(OPC_NOP, BE);
    pkt(OPC_GO, OK);
    pkt(OPC_NOP, BE);
    chk(n_res, 32'h0);
    pkt(16'h2D85, OK);
    pkt(OPC_NOP, 17'h0700D);
    pkt(OPC_NOP, 17'h00005);
    halted <= 1'b1;
    pkt(16'h218B, OK);
    pkt(OPC_NOP, 17'h0F00D);
    pkt(OPC_NOP, 17'h0000B);
    pkt(OPC_WCTL, OK);
    pkt(16'h1357, NR);
    pkt(16'h9BDF, NR);
    pkt(OPC_GO, OK);
    chk(rg_data, 32'h13579BDF);
    chk({30'h0, rg_space}, 32'h1);
    pkt(OPC_NOP, OK);
    chk(n_res, 32'h1);
    pkt(16'h208C, OK);
    pkt(16'h0246, NR);
    pkt(16'h8ACE, NR);
    pkt(16'h2C83, OK);
    chk(rg_data, 32'h02468ACE);
    chk({25'h0, rg_space, rg_sel}, 32'h0000000C);
    pkt(16'hDEAD, NR);
    pkt(16'h0042, NR);
    pkt(OPC_RCTL, OK);
    chk(rg_data, 32'hDEAD0042);
    chk({25'h0, rg_space, rg_sel}, 32'h00000043);
    pkt(OPC_NOP, 17'h0B00D);
    pkt(OPC_NOP, 17'h00000);
    end_sim();
  end
endmodule // bdsp_top_bench
